// ===== rtl/pcb_bridge.sv
// pcb_bridge.sv : shared memory-mapped bridge with apb control registers
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`default_nettype none
`include "pcb_consts.svh"

module pcb_bridge import pcb_pkg::*; #(
	parameter pcb_mode_e MODE        = PCB_MODE_XING,
	parameter int        NM          = 2,
	parameter int        SPAN_W      = 12,
	parameter int        DS_BC_W     = 3,
	parameter int        PIPE_CMD    = 1,
	parameter int        PIPE_RSP    = 1,
	parameter int        CMD_DEPTH   = 4,
	parameter int        DS_MAX_PEND = 8,
	parameter int        RSP_DEPTH   = DS_MAX_PEND
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`PCB_PAW-1:0]    paddr,
	input  wire logic [`PCB_DW-1:0]     pwdata,
	output logic [`PCB_DW-1:0]          prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire pcb_req_s               up_req [NM],
	output logic [NM-1:0]               up_waitrequest,
	output pcb_data_t                   up_rdata,
	output logic [NM-1:0]               up_rdatavalid,
	output logic [SPAN_W-1:0]           ds_addr,
	output logic                        ds_read,
	output logic                        ds_write,
	output pcb_data_t                   ds_wdata,
	output pcb_be_t                     ds_be,
	output logic [((DS_BC_W > 0) ? DS_BC_W : 1)-1:0] ds_burstcount,
	input  wire logic                   ds_waitrequest,
	input  wire pcb_data_t              ds_rdata,
	input  wire logic                   ds_rdatavalid
);

	// ----------------------------------------------------------------
	// derived sizes
	// ----------------------------------------------------------------
	localparam int DSB      = (DS_BC_W > 0) ? DS_BC_W : 1;
	localparam int DS_BURST = (DS_BC_W > 0) ? (1 << (DS_BC_W - 1)) : 1;
	localparam int IDW      = (NM > 1) ? $clog2(NM) : 1;
	localparam int CMD_D    = (MODE == PCB_MODE_XING) ? CMD_DEPTH : PIPE_CMD;
	localparam int RSP_D    = (MODE == PCB_MODE_XING) ? RSP_DEPTH : PIPE_RSP;
	// pending reads bounded by response room in the crossing variant
	localparam int PEND_CAP = (MODE == PCB_MODE_XING) ? RSP_DEPTH : DS_MAX_PEND;
	localparam int CNTW     = `PCB_CNTW;
	localparam logic [CNTW-1:0]   CAP_C  = CNTW'(PEND_CAP);
	localparam pcb_bc_t           BURST_C = `PCB_BCW'(DS_BURST);
	localparam logic [SPAN_W-1:0] BYTES_C = SPAN_W'(`PCB_DW / 8);
	localparam pcb_addr_t         SPAN_MASK =
		pcb_addr_t'((64'h1 << SPAN_W) - 64'h1);

	// ----------------------------------------------------------------
	// apb registers
	// ----------------------------------------------------------------
	logic            ctrl_en;
	pcb_addr_t       base;
	logic [CNTW-1:0] max_pend;
	logic [CNTW-1:0] up_pend;
	logic [CNTW-1:0] ds_out;
	pcb_data_t       stat_word;
	wire logic       sel_ctrl = (paddr == `PCB_REG_CTRL);
	wire logic       sel_base = (paddr == `PCB_REG_BASE);
	wire logic       sel_pend = (paddr == `PCB_REG_PEND);
	wire logic       sel_stat = (paddr == `PCB_REG_STAT);
	wire logic       hit      = sel_ctrl | sel_base | sel_pend | sel_stat;
	wire logic       apb_wr   = psel & penable & pwrite & hit;
	wire logic       cq_valid;
	wire pcb_data_t  rd_mux   = sel_ctrl ? {31'h0, ctrl_en} :
		sel_base ? base :
		sel_pend ? {16'h0, max_pend} :
		sel_stat ? stat_word : '0;

	always_comb begin
		stat_word = '0;
		stat_word[CNTW-1:0] = up_pend;
		stat_word[`PCB_STAT_BUSY_BIT] = cq_valid | (up_pend != '0);
	end

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	// read data is caught in the setup cycle so that it leaves a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata   <= '0;
			ctrl_en  <= `PCB_CTRL_RST;
			base     <= `PCB_BASE_RST & ~SPAN_MASK;
			max_pend <= CAP_C;
		end else begin
			if (psel & ~penable) begin
				prdata <= rd_mux;
			end
			if (apb_wr & sel_ctrl) begin
				ctrl_en <= pwdata[`PCB_CTRL_EN_BIT];
			end
			if (apb_wr & sel_base) begin
				base <= pwdata & ~SPAN_MASK;
			end
			if (apb_wr & sel_pend) begin
				max_pend <= pwdata[CNTW-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// round-robin arbiter: one master at a time
	// ----------------------------------------------------------------
	logic [NM-1:0]  req;
	logic [IDW-1:0] rr_last;
	logic [IDW-1:0] gnt_id;
	logic           any_req;

	genvar gi;
	generate
		for (gi = 0; gi < NM; gi++) begin : g_req
			assign req[gi] = up_req[gi].read | up_req[gi].write;
		end
	endgenerate

	always_comb begin
		gnt_id  = rr_last;
		any_req = 1'b0;
		for (int k = 1; k <= NM; k++) begin
			if (!any_req && req[IDW'((int'(rr_last) + k) % NM)]) begin
				any_req = 1'b1;
				gnt_id  = IDW'((int'(rr_last) + k) % NM);
			end
		end
	end

	// ----------------------------------------------------------------
	// decode, pending limit and acceptance
	// ----------------------------------------------------------------
	wire pcb_req_s        sel      = up_req[gnt_id];
	wire pcb_addr_t       off_full = sel.addr - base;
	wire logic            in_rng   = ((off_full & ~SPAN_MASK) == '0);
	wire logic [CNTW-1:0] pend_lim = (max_pend < CAP_C) ? max_pend : CAP_C;
	wire logic [CNTW:0]   pend_sum = {1'b0, up_pend} + (CNTW+1)'(sel.bcount);
	wire logic            pend_ok  = (pend_sum <= {1'b0, pend_lim});
	wire logic            ord_in_ready;
	wire logic            cmd_in_ready;
	wire logic            rd_ok    = ~sel.read | (ord_in_ready & pend_ok);
	wire logic            cmd_in_v = any_req & ctrl_en & rd_ok;
	wire logic            accept   = cmd_in_v & cmd_in_ready;
	wire logic            acc_rd   = accept & sel.read;
	pcb_cmd_s             cmd_in;

	always_comb begin
		cmd_in        = '0;
		cmd_in.write  = sel.write;
		cmd_in.miss   = ~in_rng;
		cmd_in.off    = off_full;
		cmd_in.wdata  = sel.wdata;
		cmd_in.be     = sel.be;
		// writes are single beats; only reads carry a burst length
		cmd_in.bcount = sel.write ? `PCB_BCW'(1) : sel.bcount;
	end

	generate
		for (gi = 0; gi < NM; gi++) begin : g_wait
			assign up_waitrequest[gi] = ~(accept & (gnt_id == IDW'(gi)));
		end
	endgenerate

	// ----------------------------------------------------------------
	// command stage: pipeline register or crossing buffer
	// ----------------------------------------------------------------
	pcb_cmd_s   cq;
	wire logic  cq_ready;

	pcb_fifo #(
		.W     ($bits(pcb_cmd_s)),
		.DEPTH (CMD_D)
	) u_cmd (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (cmd_in_v),
		.in_ready  (cmd_in_ready),
		.in_data   (cmd_in),
		.out_valid (cq_valid),
		.out_ready (cq_ready),
		.out_data  (cq)
	);

	// ----------------------------------------------------------------
	// issue with burst splitting
	// ----------------------------------------------------------------
	logic              active;
	pcb_bc_t           rem;
	logic [SPAN_W-1:0] cur_off;
	wire pcb_bc_t      eff_rem = active ? rem : cq.bcount;
	wire logic [SPAN_W-1:0] eff_off = active ? cur_off : cq.off[SPAN_W-1:0];
	wire pcb_bc_t      chunk   = (eff_rem > BURST_C) ? BURST_C : eff_rem;
	// out-of-range reads answer zero words one at a time
	wire pcb_bc_t      step    = cq.miss ? `PCB_BCW'(1) : chunk;
	wire logic         is_last = (step == eff_rem);
	wire logic         go_ds   = cq_valid & ~cq.miss;
	wire logic         ds_take = go_ds & ~ds_waitrequest;
	// a miss read waits until all forwarded reads are back, keeping order
	wire logic         miss_go = cq_valid & cq.miss & (cq.write | (ds_out == '0));
	wire logic         advance = ds_take | miss_go;
	wire logic         inject  = miss_go & ~cq.write;

	assign cq_ready      = advance & is_last;
	assign ds_read       = go_ds & ~cq.write;
	assign ds_write      = go_ds & cq.write;
	assign ds_addr       = eff_off;
	assign ds_wdata      = cq.wdata;
	assign ds_be         = cq.be;
	assign ds_burstcount = DSB'(chunk);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active  <= 1'b0;
			rem     <= '0;
			cur_off <= '0;
		end else if (advance) begin
			active  <= ~is_last;
			rem     <= eff_rem - step;
			cur_off <= eff_off + SPAN_W'(step) * BYTES_C;
		end
	end

	// ----------------------------------------------------------------
	// response stage and ordering
	// ----------------------------------------------------------------
	wire logic      rsp_in_v = ds_rdatavalid | inject;
	wire pcb_data_t rsp_in_d = ds_rdatavalid ? ds_rdata : '0;
	wire logic      rsp_in_ready;
	wire logic      rq_valid;
	wire logic      ord_valid;
	wire logic [IDW+`PCB_BCW-1:0] ord_head;
	wire logic [IDW-1:0] ord_id = ord_head[IDW+`PCB_BCW-1:`PCB_BCW];
	wire pcb_bc_t   ord_len = ord_head[`PCB_BCW-1:0];
	pcb_bc_t        ord_cnt;
	wire logic      ord_pop = rq_valid & ((ord_cnt + 1'b1) == ord_len);

	// upstream cannot stall reads, so the buffer is never pushed full
	pcb_fifo #(
		.W     (`PCB_DW),
		.DEPTH (RSP_D)
	) u_rsp (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (rsp_in_v),
		.in_ready  (rsp_in_ready),
		.in_data   (rsp_in_d),
		.out_valid (rq_valid),
		.out_ready (1'b1),
		.out_data  (up_rdata)
	);

	pcb_fifo #(
		.W     (IDW + `PCB_BCW),
		.DEPTH (PEND_CAP)
	) u_ord (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (acc_rd),
		.in_ready  (ord_in_ready),
		.in_data   ({gnt_id, sel.bcount}),
		.out_valid (ord_valid),
		.out_ready (ord_pop),
		.out_data  (ord_head)
	);

	generate
		for (gi = 0; gi < NM; gi++) begin : g_rdv
			assign up_rdatavalid[gi] = rq_valid & ord_valid &
				(ord_id == IDW'(gi));
		end
	endgenerate

	wire logic [CNTW-1:0] next_pend = up_pend +
		(acc_rd ? CNTW'(sel.bcount) : '0) - CNTW'(rq_valid);
	wire logic [CNTW-1:0] next_out = ds_out +
		((ds_take & ~cq.write) ? CNTW'(chunk) : '0) - CNTW'(ds_rdatavalid);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rr_last <= '0;
			up_pend <= '0;
			ds_out  <= '0;
			ord_cnt <= '0;
		end else begin
			if (accept) begin
				rr_last <= gnt_id;
			end
			up_pend <= next_pend;
			ds_out  <= next_out;
			if (rq_valid) begin
				ord_cnt <= ord_pop ? '0 : ord_cnt + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_chunk_fits;
		@(posedge pclk) disable iff (!presetn)
		(ds_read | ds_write) |-> (int'(ds_burstcount) <= DS_BURST) &&
			(ds_burstcount != '0);
	endproperty
	a_chunk_fits: assert property (p_chunk_fits)
		else $error("downstream burst longer than slave allows");

	property p_no_burst;
		@(posedge pclk) disable iff (!presetn)
		(DS_BC_W == 0 && (ds_read | ds_write)) |-> ds_burstcount == 1'b1;
	endproperty
	a_no_burst: assert property (p_no_burst)
		else $error("non-bursting slave given a burst");

	property p_one_grant;
		@(posedge pclk) disable iff (!presetn)
		$onehot0(~up_waitrequest);
	endproperty
	a_one_grant: assert property (p_one_grant)
		else $error("more than one master accepted");

	property p_strip;
		@(posedge pclk) disable iff (!presetn)
		(accept && in_rng) |-> ((sel.addr & ~SPAN_MASK) == base) &&
			(off_full[SPAN_W-1:0] == sel.addr[SPAN_W-1:0]);
	endproperty
	a_strip: assert property (p_strip)
		else $error("forwarded address is not base stripped");

	property p_pipe_one;
		@(posedge pclk) disable iff (!presetn)
		(CMD_D == 1 && accept && in_rng) |=> (ds_read | ds_write) &&
			ds_addr == $past(off_full[SPAN_W-1:0]);
	endproperty
	a_pipe_one: assert property (p_pipe_one)
		else $error("command not issued one cycle after accept");

	property p_pend_cap;
		@(posedge pclk) disable iff (!presetn)
		acc_rd |=> (up_pend <= CAP_C) && (up_pend != '0);
	endproperty
	a_pend_cap: assert property (p_pend_cap)
		else $error("pending reads exceed the limit");

	property p_full_stall;
		@(posedge pclk) disable iff (!presetn)
		(!cmd_in_ready || !ctrl_en) |-> (&up_waitrequest);
	endproperty
	a_full_stall: assert property (p_full_stall)
		else $error("request taken while command path full");

	property p_rsp_room;
		@(posedge pclk) disable iff (!presetn)
		rsp_in_v |-> rsp_in_ready;
	endproperty
	a_rsp_room: assert property (p_rsp_room)
		else $error("response lost on full buffer");

	property p_in_order;
		@(posedge pclk) disable iff (!presetn)
		rq_valid |-> ord_valid && $onehot(up_rdatavalid);
	endproperty
	a_in_order: assert property (p_in_order)
		else $error("response without a matching read");

endmodule

`default_nettype wire

// ===== rtl/pcb_consts.svh
// pcb_consts.svh : offsets, field positions, reset values and widths
`ifndef PCB_CONSTS_SVH
`define PCB_CONSTS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define PCB_AW            32
`define PCB_DW            32
`define PCB_BEW           4
`define PCB_BCW           4
`define PCB_PAW           8
`define PCB_CNTW          16

// ----------------------------------------------------------------
// register offsets (byte addresses on apb)
// ----------------------------------------------------------------
`define PCB_REG_CTRL      8'h00
`define PCB_REG_BASE      8'h04
`define PCB_REG_PEND      8'h08
`define PCB_REG_STAT      8'h0C

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PCB_CTRL_EN_BIT   0
`define PCB_STAT_BUSY_BIT 16
`define PCB_CTRL_RST      1'b1
`define PCB_BASE_RST      32'h00001000

`endif

// ===== rtl/pcb_pkg.sv
// pcb_pkg.sv : types shared by the bridge and its tests
`default_nettype none
`include "pcb_consts.svh"

package pcb_pkg;

	// ----------------------------------------------------------------
	// variants and carriers
	// ----------------------------------------------------------------
	typedef enum {PCB_MODE_PIPE, PCB_MODE_XING} pcb_mode_e;

	typedef logic [`PCB_AW-1:0]  pcb_addr_t;
	typedef logic [`PCB_DW-1:0]  pcb_data_t;
	typedef logic [`PCB_BEW-1:0] pcb_be_t;
	typedef logic [`PCB_BCW-1:0] pcb_bc_t;

	typedef struct packed {
		logic      read;
		logic      write;
		pcb_addr_t addr;
		pcb_data_t wdata;
		pcb_be_t   be;
		pcb_bc_t   bcount;
	} pcb_req_s;

	typedef struct packed {
		logic      write;
		logic      miss;
		pcb_addr_t off;
		pcb_data_t wdata;
		pcb_be_t   be;
		pcb_bc_t   bcount;
	} pcb_cmd_s;

endpackage

`default_nettype wire

// ===== rtl/pcb_fifo.sv
// pcb_fifo.sv : synchronous fifo, depth 0 is a plain wire-through
`default_nettype none

module pcb_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 2
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);

	generate
		if (DEPTH == 0) begin : g_wire
			assign in_ready  = out_ready;
			assign out_valid = in_valid;
			assign out_data  = in_data;
		end else begin : g_mem
			localparam int          PW     = (DEPTH > 1) ? $clog2(DEPTH) : 1;
			localparam logic [PW:0] FULL_N = (PW+1)'(DEPTH);
			localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

			logic [W-1:0]  mem [DEPTH];
			logic [PW-1:0] wr_ptr;
			logic [PW-1:0] rd_ptr;
			logic [PW:0]   count;
			wire logic     push;
			wire logic     pop;

			// a full stage still accepts when it drains in the same cycle
			assign in_ready  = (count != FULL_N) | out_ready;
			assign out_valid = (count != '0);
			assign out_data  = mem[rd_ptr];
			assign push      = in_valid & in_ready;
			assign pop       = out_valid & out_ready;

			always_ff @(posedge pclk) begin
				if (push) begin
					mem[wr_ptr] <= in_data;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					wr_ptr <= '0;
					rd_ptr <= '0;
					count  <= '0;
				end else begin
					if (push) begin
						wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
					end
					if (pop) begin
						rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
					end
					count <= count + (PW+1)'(push) - (PW+1)'(pop);
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ===== tb/pcb_slave_model.sv
// pcb_slave_model.sv : downstream slave standing behind the bridge
`default_nettype none

module pcb_slave_model import pcb_pkg::*; (
	input  wire logic        pclk,
	input  wire logic        stall,
	input  wire logic [11:0] ds_addr,
	input  wire logic        ds_read,
	input  wire logic        ds_write,
	input  wire pcb_data_t   ds_wdata,
	input  wire logic [2:0]  ds_burstcount,
	output logic             ds_waitrequest,
	output pcb_data_t        ds_rdata,
	output logic             ds_rdatavalid,
	output logic [11:0]      wr_off,
	output pcb_data_t        wr_data,
	output int               wr_cnt,
	output int               bad_cnt
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [11:0] q [$];

	// ----------------------------------------------------------------
	// command side
	// ----------------------------------------------------------------
	assign ds_waitrequest = stall;

	initial begin
		ds_rdata = 32'h0;
		ds_rdatavalid = 1'b0;
		wr_off = 12'h0;
		wr_data = 32'h0;
		wr_cnt = 0;
		bad_cnt = 0;
	end

	// ----------------------------------------------------------------
	// read data one cycle after accept, one word per cycle
	// ----------------------------------------------------------------
	always @(posedge pclk) begin
		if (ds_read && !stall) begin
			// a burst wider than this slave takes is counted as a fault
			if (ds_burstcount == 3'h0 || ds_burstcount > 3'h4) begin
				bad_cnt <= bad_cnt + 1;
			end
			for (int k = 0; k < int'(ds_burstcount); k++) begin
				q.push_back(ds_addr + 12'(4 * k));
			end
		end
		if (ds_write && !stall) begin
			wr_off <= ds_addr;
			wr_data <= ds_wdata;
			wr_cnt <= wr_cnt + 1;
		end
		if (q.size() > 0) begin
			ds_rdata <= {20'hC0DE0, q.pop_front()};
			ds_rdatavalid <= 1'b1;
		end else begin
			// idle bus inverts the last word every cycle, so the stale word shows again on alternate cycles
			ds_rdata <= ~ds_rdata;
			ds_rdatavalid <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ===== tb/pipeline_clock_crossing_bridge_bench.sv
// pipeline_clock_crossing_bridge_bench.sv : self-checking bench for the bridge
`default_nettype none
`include "pcb_consts.svh"

module pipeline_clock_crossing_bridge_bench import pcb_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        stall, ds_read, ds_write, ds_wait, ds_rdv;
	logic [7:0]  paddr;
	logic [1:0]  up_wait, up_rdv;
	logic [2:0]  ds_bc;
	logic [11:0] ds_addr, wr_off;
	pcb_data_t   pwdata, prdata, up_rdata, ds_wdata, ds_rdata, wr_data;
	pcb_be_t     ds_be, wr_be;
	pcb_req_s    up_req [2];
	int          wr_cnt, bad_cnt, miscompares, cmp_count, lat, n0;

	// ----------------------------------------------------------------
	// design and far side
	// ----------------------------------------------------------------
	pcb_bridge #(.MODE(PCB_MODE_PIPE), .SPAN_W(12), .DS_BC_W(3)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.up_req(up_req), .up_waitrequest(up_wait), .up_rdata(up_rdata),
		.up_rdatavalid(up_rdv), .ds_addr(ds_addr), .ds_read(ds_read),
		.ds_write(ds_write), .ds_wdata(ds_wdata), .ds_be(ds_be),
		.ds_burstcount(ds_bc), .ds_waitrequest(ds_wait),
		.ds_rdata(ds_rdata), .ds_rdatavalid(ds_rdv));

	pcb_slave_model slv (.pclk(pclk), .stall(stall), .ds_addr(ds_addr),
		.ds_read(ds_read), .ds_write(ds_write), .ds_wdata(ds_wdata),
		.ds_burstcount(ds_bc), .ds_waitrequest(ds_wait),
		.ds_rdata(ds_rdata), .ds_rdatavalid(ds_rdv), .wr_off(wr_off),
		.wr_data(wr_data), .wr_cnt(wr_cnt), .bad_cnt(bad_cnt));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// ----------------------------------------------------------------
	// checking and closing
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic wait_expired();
		chk(32'h0, 32'h1);
		complete_run();
	endtask

	// one grant at a time across both masters
	always @(posedge pclk) begin
		if (presetn) begin
			chk(32'(up_wait[0] | up_wait[1]), 32'h1);
		end
	end

	// byte enables seen by the slave on its last accepted write
	always @(posedge pclk) begin
		if (ds_write && !ds_wait) begin
			wr_be <= ds_be;
		end
	end

	// ----------------------------------------------------------------
	// apb master and upstream master tasks
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input pcb_data_t wd,
			output pcb_data_t rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 20) wait_expired();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, input pcb_data_t exp,
			input logic e);
		pcb_data_t d;
		logic      er;
		apb(1'b0, a, 32'h0, d, er);
		chk(d, exp);
		chk(32'(er), 32'(e));
	endtask

	task automatic wr_reg(input logic [7:0] a, input pcb_data_t d);
		pcb_data_t r;
		logic      er;
		apb(1'b1, a, d, r, er);
	endtask

	// request held until the edge that sees waitrequest low
	task automatic issue(input int m, input logic wr, input pcb_addr_t a,
			input pcb_bc_t bc);
		int n;
		@(posedge pclk);
		up_req[m] <= '{read: !wr, write: wr, addr: a,
			wdata: 32'h5A5A1234 ^ a, be: ~a[5:2], bcount: bc};
		for (n = 0; n < 200; n++) begin
			@(posedge pclk);
			if (up_wait[m] === 1'b0) break;
		end
		if (n == 200) wait_expired();
		up_req[m] <= '0;
	endtask

	task automatic collect(input int m, input int cnt, input logic [11:0] off,
			output int first);
		int n, k;
		k = 0;
		first = 0;
		for (n = 1; n <= 300 && k < cnt; n++) begin
			@(posedge pclk);
			if (up_rdv[m] === 1'b1) begin
				if (k == 0) first = n;
				chk(up_rdata, {20'hC0DE0, off + 12'(4 * k)});
				k++;
			end
		end
		if (k < cnt) wait_expired();
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, stall} = 5'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		up_req[0] = '0;
		up_req[1] = '0;
		miscompares = 0;
		cmp_count = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd_reg(`PCB_REG_CTRL, 32'h1, 1'b0);
		rd_reg(`PCB_REG_BASE, `PCB_BASE_RST, 1'b0);
		rd_reg(`PCB_REG_PEND, 32'h8, 1'b0);
		rd_reg(`PCB_REG_STAT, 32'h0, 1'b0);
		rd_reg(8'h10, 32'h0, 1'b1);
		$display("test registers done");
		issue(0, 1'b0, 32'h0000102C, 4'h1);
		collect(0, 1, 12'h02C, lat);
		chk(32'(lat), 32'h3);
		$display("test single read done");
		// long burst against a short one, both masters at once
		fork
			begin
				issue(1, 1'b0, 32'h00001100, 4'h8);
				collect(1, 8, 12'h100, lat);
			end
			begin
				issue(0, 1'b0, 32'h00001200, 4'h3);
				collect(0, 3, 12'h200, lat);
			end
		join
		chk(32'(bad_cnt), 32'h0);
		$display("test burst split done");
		n0 = wr_cnt;
		issue(0, 1'b1, 32'h00001020, 4'h1);
		for (int n = 0; n < 50 && wr_cnt == n0; n++) @(posedge pclk);
		chk(32'(wr_off), 32'h020);
		chk(wr_data, 32'h5A5A1234 ^ 32'h00001020);
		chk(32'(wr_be), 32'h7);
		issue(0, 1'b1, 32'h00003000, 4'h1);
		repeat (20) @(posedge pclk);
		chk(32'(wr_cnt), 32'(n0 + 1));
		$display("test writes done");
		wr_reg(`PCB_REG_BASE, 32'h00002ABC);
		rd_reg(`PCB_REG_BASE, 32'h00002000, 1'b0);
		issue(1, 1'b0, 32'h00002010, 4'h1);
		collect(1, 1, 12'h010, lat);
		$display("test base move done");
		// slave stalls while the pending limit is used up
		wr_reg(`PCB_REG_PEND, 32'h2);
		stall <= 1'b1;
		issue(0, 1'b0, 32'h00002040, 4'h2);
		fork
			begin
				repeat (8) begin
					@(posedge pclk);
					chk(32'(up_wait[1]), 32'h1);
				end
				rd_reg(`PCB_REG_STAT, 32'h00010002, 1'b0);
				stall <= 1'b0;
			end
			begin
				issue(1, 1'b0, 32'h00002050, 4'h1);
				collect(1, 1, 12'h050, lat);
			end
			collect(0, 2, 12'h040, lat);
		join
		$display("test pending limit done");
		// a disabled bridge holds off new requests until enabled again
		wr_reg(`PCB_REG_CTRL, 32'h0);
		rd_reg(`PCB_REG_CTRL, 32'h0, 1'b0);
		fork
			issue(0, 1'b0, 32'h00002060, 4'h1);
			begin
				repeat (6) begin
					@(posedge pclk);
					chk(32'(up_wait[0]), 32'h1);
				end
				wr_reg(`PCB_REG_CTRL, 32'h1);
			end
		join
		collect(0, 1, 12'h060, lat);
		$display("test enable done");
		complete_run();
	end

endmodule

`default_nettype wire
